// ===== common/ssg_consts.svh
`ifndef SSG_CONSTS_SVH
`define SSG_CONSTS_SVH

// Bitmap geometry
`define SSG_MAP_W 64
`define SSG_HALF_W 32
`define SSG_PRIV_W 2
`define SSG_PRIV_KERNEL 2'h0

// Component bit positions
`define SSG_BIT_FPU 0
`define SSG_BIT_SIMD 1
`define SSG_BIT_VEC_UPPER 2
`define SSG_BIT_BOUND_REGS 3
`define SSG_BIT_BOUND_CSR 4
`define SSG_BIT_OPMASK 5
`define SSG_BIT_WIDE_UPPER 6
`define SSG_BIT_EXTRA_WIDE 7
`define SSG_BIT_TRACE 8
`define SSG_BIT_PKEY 9
`define SSG_BIT_FLOW_USER 11
`define SSG_BIT_FLOW_SUPER 12
`define SSG_BIT_DUTY 13
`define SSG_BIT_PERF 16
`define SSG_BIT_SPECIAL 63

// Component classes
`define SSG_CLS_NONE 2'h0
`define SSG_CLS_USER 2'h1
`define SSG_CLS_SUPER 2'h2

// Classification masks
`define SSG_USER_MASK 64'h0000_0000_0000_02FF
`define SSG_SUPER_MASK 64'h0000_0000_0001_3900
`define SSG_GATED_MASK 64'h0000_0000_0000_00FC
`define SSG_UNGATED_MASK 64'h0000_0000_0001_3B03
`define SSG_RESV_MASK 64'hFFFF_FFFF_FFFE_C400

// Wide-vector without SIMD pattern on bits 2:1
`define SSG_VEC_NO_SIMD 2'h2

// Register access
`define SSG_SUPER_EN_INDEX 32'h0000_0DA0
`define SSG_USER_EN_SEL 32'h0000_0000
`define SSG_USER_EN_RESET 64'h0000_0000_0000_0001
`define SSG_SUPER_EN_RESET 64'h0000_0000_0000_0000

`endif

// ===== common/ssg_pkg.sv
package ssg_pkg;

  typedef enum logic [2:0] {
    SSG_OP_EN_READ    = 3'h0,
    SSG_OP_EN_WRITE   = 3'h1,
    SSG_OP_SAVE       = 3'h2,
    SSG_OP_SAVE_OPT   = 3'h3,
    SSG_OP_SAVE_COMP  = 3'h4,
    SSG_OP_SAVE_SUPER = 3'h5,
    SSG_OP_RESTORE    = 3'h6,
    SSG_OP_REST_SUPER = 3'h7
  } ssg_op_t;

  typedef struct packed {
    logic        valid;
    ssg_op_t     op;
    logic [31:0] sel;
    logic [31:0] mask_high_reg;
    logic [31:0] mask_low_reg;
  } ssg_req_t;

  typedef struct packed {
    logic        valid;
    logic        invalid_opcode_fault;
    logic        general_protection_fault;
    logic [63:0] act_mask;
    logic [63:0] rdata;
  } ssg_resp_t;

  typedef struct packed {
    logic valid;
    logic invalid_opcode_fault;
  } ssg_feat_resp_t;

endpackage

// ===== core/ssg_gate.sv
`timescale 1ns/1ns
`include "ssg_consts.svh"
// Function
// - Every component selection is a 64-bit bitmap, one bit per component.
// - Bits 0, 1, 2 select floating-point, SIMD and vector-upper state.
// - Bits 4:3 select bound registers and bound config/status state.
// - Bits 7:5 select opmask, wide upper halves and extra wide registers.
// - Bit 8 trace, bit 9 key rights, bits 12:11 flow protection.
// - Bit 13 duty-cycle state, bit 16 performance-state control.
// - Bits 10, 15:14, 62:17 reserved; bit 63 holds no component.
// - Components 0-7 and 9 are user; 8, 11-13, 16 supervisor.
// - Instruction mask comes from the high and low mask registers.
// - A user component clear in the user enable register is never acted on.
// - Supervisor save/restore act on supervisor bits set in supervisor enable.
// - Non-supervisor saves and plain restore never manage supervisor components.
// - Write and supervisor save/restore need privilege 0; others run anywhere.
// - Gated components unmodifiable while disabled; contents kept on disable.
// - Gated feature instruction with a component not enabled faults invalid-opcode.
// - OS enable bit 0 makes every gated feature act as disabled.
// - Ungated features stay usable regardless of OS bit and user enable.
// - The group has eight instructions: read, write, four saves, two restores.
// - User enable bit 0 always reads one, also right after reset.
// - Write with selector 0 at privilege 0 loads the full 64-bit value.
// - Write faulting protection when value bits 2:1 equal 10b.
module ssg_gate (
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Sync reset, active low
  input wire logic os_enable_bit, // Control register 4 bit 18
  input wire logic [`SSG_PRIV_W-1:0] current_privilege_level, // Current privilege
  input wire ssg_pkg::ssg_req_t instr_req, // Instruction request
  input wire logic msr_rd_en, // Model register read strobe
  input wire logic msr_wr_en, // Model register write strobe
  input wire logic [31:0] msr_index, // Model register index
  input wire logic [`SSG_MAP_W-1:0] msr_wdata, // Model register write data
  input wire logic feat_check_valid, // Gated feature instruction issued
  input wire logic [`SSG_MAP_W-1:0] feat_comp_req, // Components that instruction uses
  output ssg_pkg::ssg_resp_t instr_resp, // Instruction answer
  output ssg_pkg::ssg_resp_t msr_resp, // Model register answer
  output ssg_pkg::ssg_feat_resp_t feat_resp, // Feature check answer
  output logic [`SSG_MAP_W-1:0] comp_modify_allow, // Per-component write permit
  output logic [`SSG_MAP_W-1:0] user_state_enable_reg, // User enable value
  output logic [`SSG_MAP_W-1:0] supervisor_state_enable_reg // Supervisor enable value
);

  logic [`SSG_MAP_W-1:0] user_en_ff;
  logic [`SSG_MAP_W-1:0] nxt_user_en;
  logic [`SSG_MAP_W-1:0] super_en_ff;
  logic [`SSG_MAP_W-1:0] nxt_super_en;
  ssg_pkg::ssg_resp_t instr_resp_ff;
  ssg_pkg::ssg_resp_t nxt_instr_resp;
  ssg_pkg::ssg_resp_t msr_resp_ff;
  ssg_pkg::ssg_resp_t nxt_msr_resp;
  ssg_pkg::ssg_feat_resp_t feat_resp_ff;
  ssg_pkg::ssg_feat_resp_t nxt_feat_resp;
  logic [`SSG_MAP_W-1:0] allow_ff;
  logic [`SSG_MAP_W-1:0] nxt_allow;

  logic [`SSG_MAP_W-1:0] user_map;
  logic [`SSG_MAP_W-1:0] super_map;
  logic [`SSG_MAP_W-1:0] gated_map;
  logic [`SSG_MAP_W-1:0] ungated_map;

  logic [`SSG_MAP_W-1:0] instr_mask;
  logic priv_ok;
  logic [`SSG_MAP_W-1:0] user_view;
  logic [`SSG_MAP_W-1:0] super_view;

  // Class of one bitmap position
  function automatic logic [1:0] comp_class(input int unsigned pos);
    logic [1:0] cls;
    cls = `SSG_CLS_NONE;
    if (pos == `SSG_BIT_FPU) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_SIMD) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_VEC_UPPER) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_BOUND_REGS) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_BOUND_CSR) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_OPMASK) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_WIDE_UPPER) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_EXTRA_WIDE) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_TRACE) begin
      cls = `SSG_CLS_SUPER;
    end else if (pos == `SSG_BIT_PKEY) begin
      cls = `SSG_CLS_USER;
    end else if (pos == `SSG_BIT_FLOW_USER) begin
      cls = `SSG_CLS_SUPER;
    end else if (pos == `SSG_BIT_FLOW_SUPER) begin
      cls = `SSG_CLS_SUPER;
    end else if (pos == `SSG_BIT_DUTY) begin
      cls = `SSG_CLS_SUPER;
    end else if (pos == `SSG_BIT_PERF) begin
      cls = `SSG_CLS_SUPER;
    end else begin
      cls = `SSG_CLS_NONE;
    end
    comp_class = cls;
  endfunction

  // Component whose feature needs user enable gating
  function automatic logic comp_gated(input int unsigned pos);
    logic gated;
    gated = 1'b0;
    if (pos == `SSG_BIT_FPU) begin
      gated = 1'b0;
    end else if (pos == `SSG_BIT_SIMD) begin
      gated = 1'b0;
    end else if (pos == `SSG_BIT_VEC_UPPER) begin
      gated = 1'b1;
    end else if (pos == `SSG_BIT_BOUND_REGS) begin
      gated = 1'b1;
    end else if (pos == `SSG_BIT_BOUND_CSR) begin
      gated = 1'b1;
    end else if (pos == `SSG_BIT_OPMASK) begin
      gated = 1'b1;
    end else if (pos == `SSG_BIT_WIDE_UPPER) begin
      gated = 1'b1;
    end else if (pos == `SSG_BIT_EXTRA_WIDE) begin
      gated = 1'b1;
    end else begin
      gated = 1'b0;
    end
    comp_gated = gated;
  endfunction

  // Per-position class maps
  always_comb begin
    user_map = '0;
    super_map = '0;
    gated_map = '0;
    ungated_map = '0;
    for (int i = 0; i < `SSG_MAP_W; i++) begin
      user_map[i] = (comp_class(i) == `SSG_CLS_USER);
      super_map[i] = (comp_class(i) == `SSG_CLS_SUPER);
      gated_map[i] = comp_gated(i);
      ungated_map[i] = (comp_class(i) != `SSG_CLS_NONE) && !comp_gated(i);
    end
  end

  // Any reserved or special position set
  function automatic logic has_resv(input logic [`SSG_MAP_W-1:0] map);
    has_resv = |(map & `SSG_RESV_MASK);
  endfunction

  // Only user components
  function automatic logic [`SSG_MAP_W-1:0] user_part(input logic [`SSG_MAP_W-1:0] map);
    user_part = map & `SSG_USER_MASK;
  endfunction

  // Only supervisor components
  function automatic logic [`SSG_MAP_W-1:0] super_part(input logic [`SSG_MAP_W-1:0] map);
    super_part = map & `SSG_SUPER_MASK;
  endfunction

  // User enable value legal for a write
  function automatic logic user_val_bad(input logic [`SSG_MAP_W-1:0] val);
    logic bad;
    bad = 1'b0;
    if (!val[`SSG_BIT_FPU]) begin
      bad = 1'b1;
    end
    if (val[`SSG_BIT_VEC_UPPER:`SSG_BIT_SIMD] == `SSG_VEC_NO_SIMD) begin
      bad = 1'b1;
    end
    if (has_resv(val) || (|super_part(val))) begin
      bad = 1'b1;
    end
    user_val_bad = bad;
  endfunction

  // Supervisor enable value legal for a write
  function automatic logic super_val_bad(input logic [`SSG_MAP_W-1:0] val);
    super_val_bad = has_resv(val) || (|user_part(val));
  endfunction

  always_comb begin
    instr_mask = {instr_req.mask_high_reg, instr_req.mask_low_reg};
    priv_ok = (current_privilege_level == `SSG_PRIV_KERNEL);
    user_view = user_en_ff & user_map;
    super_view = super_en_ff & super_map;
  end

  // Instruction decode and enable register write
  always_comb begin
    nxt_instr_resp = '0;
    nxt_user_en = user_en_ff;
    nxt_instr_resp.valid = instr_req.valid;
    if (instr_req.valid) begin
      if (!os_enable_bit) begin
        nxt_instr_resp.invalid_opcode_fault = 1'b1;
      end else begin
        case (instr_req.op)
          ssg_pkg::SSG_OP_EN_READ: begin
            if (instr_req.sel != `SSG_USER_EN_SEL) begin
              nxt_instr_resp.general_protection_fault = 1'b1;
            end else begin
              nxt_instr_resp.rdata = user_en_ff;
            end
          end
          ssg_pkg::SSG_OP_EN_WRITE: begin
            if (!priv_ok) begin
              nxt_instr_resp.general_protection_fault = 1'b1;
            end else if (instr_req.sel != `SSG_USER_EN_SEL) begin
              nxt_instr_resp.general_protection_fault = 1'b1;
            end else if (user_val_bad(instr_mask)) begin
              nxt_instr_resp.general_protection_fault = 1'b1;
            end else begin
              nxt_user_en = instr_mask;
            end
          end
          ssg_pkg::SSG_OP_SAVE_SUPER, ssg_pkg::SSG_OP_REST_SUPER: begin
            if (!priv_ok) begin
              nxt_instr_resp.general_protection_fault = 1'b1;
            end else begin
              nxt_instr_resp.act_mask = instr_mask & (user_view | super_view);
            end
          end
          default: begin
            // Plain, optimized, compacted save and plain restore
            nxt_instr_resp.act_mask = instr_mask & user_view;
          end
        endcase
      end
    end
    nxt_user_en[`SSG_BIT_FPU] = 1'b1;
  end

  // Supervisor enable register at its model register index
  always_comb begin
    nxt_msr_resp = '0;
    nxt_super_en = super_en_ff;
    nxt_msr_resp.valid = msr_rd_en | msr_wr_en;
    if (msr_rd_en | msr_wr_en) begin
      if (!priv_ok || msr_index != `SSG_SUPER_EN_INDEX) begin
        nxt_msr_resp.general_protection_fault = 1'b1;
      end else if (msr_wr_en) begin
        if (super_val_bad(msr_wdata)) begin
          nxt_msr_resp.general_protection_fault = 1'b1;
        end else begin
          nxt_super_en = msr_wdata;
        end
      end else begin
        nxt_msr_resp.rdata = super_en_ff;
      end
    end
  end

  // Component modify permit and gated feature check
  always_comb begin
    nxt_allow = ungated_map;
    if (os_enable_bit) begin
      nxt_allow = nxt_allow | (user_en_ff & gated_map);
    end
    nxt_feat_resp.valid = feat_check_valid;
    nxt_feat_resp.invalid_opcode_fault = 1'b0;
    if (feat_check_valid) begin
      // Uses nxt_allow, not the registered permit, so a gated bit off blocks the feature
      nxt_feat_resp.invalid_opcode_fault = |(feat_comp_req & ~nxt_allow);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      user_en_ff <= `SSG_USER_EN_RESET;
      super_en_ff <= `SSG_SUPER_EN_RESET;
      instr_resp_ff <= '0;
      msr_resp_ff <= '0;
      feat_resp_ff <= '0;
      allow_ff <= `SSG_UNGATED_MASK;
    end else begin
      user_en_ff <= nxt_user_en;
      super_en_ff <= nxt_super_en;
      instr_resp_ff <= nxt_instr_resp;
      msr_resp_ff <= nxt_msr_resp;
      feat_resp_ff <= nxt_feat_resp;
      allow_ff <= nxt_allow;
    end
  end

  assign instr_resp = instr_resp_ff;
  assign msr_resp = msr_resp_ff;
  assign feat_resp = feat_resp_ff;
  assign comp_modify_allow = allow_ff;
  assign user_state_enable_reg = user_en_ff;
  assign supervisor_state_enable_reg = super_en_ff;

endmodule

// ===== verif/ssg_gate_checker.sv
`timescale 1ns/1ns
module ssg_gate_checker (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic os_enable_bit, // OS enable
  input wire logic [1:0] current_privilege_level, // Privilege
  input wire ssg_pkg::ssg_req_t instr_req, // Request
  input wire logic msr_rd_en, // Read strobe
  input wire logic msr_wr_en, // Write strobe
  input wire logic [31:0] msr_index, // Index
  input wire logic [63:0] msr_wdata, // Write data
  input wire logic feat_check_valid, // Check strobe
  input wire logic [63:0] feat_comp_req, // Needed parts
  input wire ssg_pkg::ssg_resp_t instr_resp, // Answer
  input wire ssg_pkg::ssg_resp_t msr_resp, // Register answer
  input wire ssg_pkg::ssg_feat_resp_t feat_resp, // Check answer
  input wire logic [63:0] comp_modify_allow, // Permit
  input wire logic [63:0] user_state_enable_reg, // User enable
  input wire logic [63:0] supervisor_state_enable_reg // Supervisor enable
);
  logic [63:0] msk_ff, u_ff, s_ff, f_ff, cur;
  logic os_ff, ok;
  assign cur = {instr_req.mask_high_reg, instr_req.mask_low_reg};
  assign ok = instr_req.valid && os_enable_bit;
  always_ff @(posedge core_clk) begin
    msk_ff <= cur;
    u_ff <= reset_n ? user_state_enable_reg : 64'h0;
    s_ff <= supervisor_state_enable_reg;
    f_ff <= feat_comp_req;
    os_ff <= reset_n && os_enable_bit;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_resp_one: assert property (instr_req.valid |=> instr_resp.valid)
    else $error("instr answer missing");
  a_os_off: assert property (instr_req.valid && !os_enable_bit |=>
    instr_resp.invalid_opcode_fault && instr_resp.act_mask == 64'h0) else $error("os off");
  a_priv_gp: assert property (ok && instr_req.op == ssg_pkg::SSG_OP_SAVE_SUPER &&
    current_privilege_level != 2'h0 |=> instr_resp.general_protection_fault) else $error("priv");
  a_user_act: assert property (ok && instr_req.op == ssg_pkg::SSG_OP_SAVE |=>
    instr_resp.act_mask == (msk_ff & u_ff & 64'h2FF)) else $error("user act");
  a_super_act: assert property (ok && instr_req.op == ssg_pkg::SSG_OP_SAVE_SUPER &&
    current_privilege_level == 2'h0 |=> instr_resp.act_mask == (msk_ff & (u_ff | s_ff)))
    else $error("super act");
  a_bit0_one: assert property (user_state_enable_reg[0])
    else $error("bit0");
  a_feat_ud: assert property (feat_check_valid |=> feat_resp.valid &&
    feat_resp.invalid_opcode_fault == |(f_ff & ~(64'h13B03 | ({64{os_ff}} & u_ff & 64'hFC))))
    else $error("feat");
  a_resv_kept: assert property (ok && instr_req.op == ssg_pkg::SSG_OP_EN_WRITE &&
    |(cur & 64'hFFFFFFFFFFFEC400) |=> instr_resp.general_protection_fault &&
    $stable(user_state_enable_reg)) else $error("resv");
  a_vec_gp: assert property (ok && instr_req.op == ssg_pkg::SSG_OP_EN_WRITE &&
    cur[2:1] == 2'h2 |=> instr_resp.general_protection_fault) else $error("vec");
  a_permit: assert property (comp_modify_allow ==
    (64'h13B03 | ({64{os_ff}} & u_ff & 64'hFC))) else $error("permit");
  a_msr_idx: assert property ((msr_rd_en || msr_wr_en) && msr_index != 32'hDA0 |=>
    msr_resp.general_protection_fault) else $error("msr index");
  c_write: cover property (ok && instr_req.op == ssg_pkg::SSG_OP_EN_WRITE);
  c_super: cover property (ok && instr_req.op == ssg_pkg::SSG_OP_SAVE_SUPER);
  c_feat: cover property (feat_resp.invalid_opcode_fault);
endmodule
bind ssg_gate ssg_gate_checker ssg_gate_checker_inst (.core_clk, .reset_n, .os_enable_bit,
  .current_privilege_level, .instr_req, .msr_rd_en, .msr_wr_en, .msr_index, .msr_wdata,
  .feat_check_valid, .feat_comp_req, .instr_resp, .msr_resp, .feat_resp, .comp_modify_allow,
  .user_state_enable_reg, .supervisor_state_enable_reg);

// ===== verif/ssg_gate_tb.sv
`timescale 1ns/1ns
module ssg_gate_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic os_enable_bit = 1'b1;
  logic [1:0] current_privilege_level = 2'h0;
  ssg_pkg::ssg_req_t instr_req = '0;
  logic msr_rd_en = 1'b0;
  logic msr_wr_en = 1'b0;
  logic [31:0] msr_index = 32'h0;
  logic [63:0] msr_wdata = 64'h0;
  logic feat_check_valid = 1'b0;
  logic [63:0] feat_comp_req = 64'h0;
  ssg_pkg::ssg_resp_t instr_resp, msr_resp;
  ssg_pkg::ssg_feat_resp_t feat_resp;
  logic [63:0] comp_modify_allow, user_state_enable_reg, supervisor_state_enable_reg;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #10 core_clk = ~core_clk;
  ssg_gate ssg_gate_inst (.core_clk, .reset_n, .os_enable_bit, .current_privilege_level,
    .instr_req, .msr_rd_en, .msr_wr_en, .msr_index, .msr_wdata, .feat_check_valid,
    .feat_comp_req, .instr_resp, .msr_resp, .feat_resp, .comp_modify_allow,
    .user_state_enable_reg, .supervisor_state_enable_reg);
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // Flags are {valid, invalid opcode, protection}
  task automatic ins(input ssg_pkg::ssg_op_t op, input logic [63:0] v, input logic [2:0] ef,
      input logic [63:0] ea);
    instr_req = {1'b1, op, 32'h0, v};
    @(negedge core_clk);
    chk("instr flags", {61'h0, ef}, {61'h0, instr_resp.valid,
      instr_resp.invalid_opcode_fault, instr_resp.general_protection_fault});
    chk("instr data", ea, instr_resp.act_mask | instr_resp.rdata);
  endtask
  task automatic msr(input logic wr, input logic [31:0] ix, input logic [63:0] d,
      input logic [2:0] ef, input logic [63:0] ed);
    {msr_wr_en, msr_rd_en, msr_index, msr_wdata} = {wr, !wr, ix, d};
    @(negedge core_clk);
    chk("msr flags", {61'h0, ef}, {61'h0, msr_resp.valid,
      msr_resp.invalid_opcode_fault, msr_resp.general_protection_fault});
    chk("msr data", ed, msr_resp.rdata);
  endtask
  task automatic feat(input logic [63:0] c, input logic ef);
    {feat_check_valid, feat_comp_req} = {1'b1, c};
    @(negedge core_clk);
    chk("feat", {62'h0, 1'b1, ef}, {62'h0, feat_resp});
  endtask
  task automatic rest;
    {instr_req, feat_check_valid, msr_wr_en, msr_rd_en} = '0;
    @(negedge core_clk);
  endtask
  task automatic t_user;
    chk("user reset", 64'h1, user_state_enable_reg);
    chk("super reset", 64'h0, supervisor_state_enable_reg);
    ins(ssg_pkg::SSG_OP_EN_WRITE, 64'h7, 3'h4, 64'h0);
    ins(ssg_pkg::SSG_OP_SAVE, '1, 3'h4, 64'h7);
    ins(ssg_pkg::SSG_OP_SAVE_OPT, 64'h13FFF, 3'h4, 64'h7);
    ins(ssg_pkg::SSG_OP_SAVE_COMP, 64'h13FFF, 3'h4, 64'h7);
    ins(ssg_pkg::SSG_OP_RESTORE, 64'h2, 3'h4, 64'h2);
    ins(ssg_pkg::SSG_OP_EN_READ, 64'h0, 3'h4, 64'h7);
    ins(ssg_pkg::SSG_OP_EN_WRITE, 64'h5, 3'h5, 64'h0);
    ins(ssg_pkg::SSG_OP_EN_WRITE, 64'h407, 3'h5, 64'h0);
    ins(ssg_pkg::SSG_OP_EN_WRITE, 64'h6, 3'h5, 64'h0);
    rest;
    chk("user kept", 64'h7, user_state_enable_reg);
  endtask
  task automatic t_super;
    msr(1'b1, 32'hDA0, 64'h100, 3'h4, 64'h0);
    msr(1'b1, 32'hDA0, 64'h8000000000000100, 3'h5, 64'h0);
    msr(1'b0, 32'hDA0, 64'h0, 3'h4, 64'h100);
    msr(1'b0, 32'hDA1, 64'h0, 3'h5, 64'h0);
    ins(ssg_pkg::SSG_OP_SAVE_SUPER, '1, 3'h4, 64'h107);
    ins(ssg_pkg::SSG_OP_REST_SUPER, 64'h100, 3'h4, 64'h100);
    ins(ssg_pkg::SSG_OP_SAVE, '1, 3'h4, 64'h7);
    current_privilege_level = 2'h3;
    ins(ssg_pkg::SSG_OP_SAVE_SUPER, '1, 3'h5, 64'h0);
    ins(ssg_pkg::SSG_OP_REST_SUPER, '1, 3'h5, 64'h0);
    ins(ssg_pkg::SSG_OP_EN_WRITE, 64'h3, 3'h5, 64'h0);
    ins(ssg_pkg::SSG_OP_SAVE_OPT, 64'h3, 3'h4, 64'h3);
    current_privilege_level = 2'h0;
    rest;
  endtask
  task automatic t_feat;
    feat(64'h4, 1'b0);
    feat(64'h20, 1'b1);
    chk("permit on", 64'h13B07, comp_modify_allow);
    os_enable_bit = 1'b0;
    rest;
    chk("permit off", 64'h13B03, comp_modify_allow);
    feat(64'h4, 1'b1);
    feat(64'h13B03, 1'b0);
    for (int i = 0; i < 8; i++) ins(ssg_pkg::ssg_op_t'(i), '1, 3'h6, 64'h0);
    os_enable_bit = 1'b1;
    ins(ssg_pkg::SSG_OP_EN_WRITE, 64'h3, 3'h4, 64'h0);
    rest;
    chk("permit drop", 64'h13B03, comp_modify_allow);
  endtask
  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    t_user;
    t_super;
    t_feat;
    give_verdict;
  end
endmodule
